// ==== rtl/pdrd_decoder.sv ====
// parallel digital reference decoder top
`timescale 1ns/10ps
module pdrd_decoder
    import pdrd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [DATA_W-1:0] data_lines,
    input  wire logic              sign_line,
    input  wire logic              read_strobe,
    input  wire logic              width_switch,
    input  wire logic              card_wide,
    input  wire logic [2:0]        input_format_select,
    input  wire logic [15:0]       display_unit_select,
    output logic      [REF_W-1:0]  reference_monitor,
    output logic      [MAG_W-1:0]  reference_magnitude,
    output logic                   reference_reverse,
    output logic                   reference_full_scale,
    output logic                   reference_valid,
    output logic                   unit_is_hz,
    output logic      [1:0]        unit_decimals,
    output logic                   unit_binary,
    output logic      [1:0]        monitor_unit,
    output logic                   digit_error,
    output logic                   format_fault,
    output logic                   read_active
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins_w;
    logic [SYNC_W-1:0] sync_q;

    assign pins_w = {width_switch, read_strobe, sign_line, data_lines};

    pdrd_pin_sync #(
        .W       (SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rst     (rst),
        .pin_in  (pins_w),
        .pin_out (sync_q)
    );

    logic [DATA_W-1:0] data_s;
    logic              sign_s;
    logic              strobe_s;
    logic              wide16_s;
    logic [11:0]       data_lo12;
    logic [7:0]        data_lo8;

    assign data_s    = sync_q[DATA_W-1:0];
    assign sign_s    = sync_q[SYNC_SIGN_BIT];
    assign strobe_s  = sync_q[SYNC_STROBE_BIT];
    assign wide16_s  = sync_q[SYNC_WIDTH_BIT];
    assign data_lo12 = data_s[11:0];
    assign data_lo8  = data_s[7:0];

    // ------------------------------------------------------------
    // format selection
    // ------------------------------------------------------------
    logic disp_bcd_force;
    logic is_binary;
    logic is_bcd5;
    logic is_bcd;
    logic fault_w;

    assign disp_bcd_force = display_unit_select >= DISP_RPM_MIN;
    assign is_binary      = (input_format_select == FMT_BINARY) && !disp_bcd_force;
    assign is_bcd5        = input_format_select == FMT_BCD_5DIG;
    assign is_bcd         = !is_binary && !is_bcd5;
    assign fault_w        = is_bcd5 && (!card_wide || !wide16_s);

    // ------------------------------------------------------------
    // binary decode
    // ------------------------------------------------------------
    logic [MAG_W-1:0] bin_mag;
    logic             bin_full;

    assign bin_mag  = !card_wide ? {9'h000, data_lo8} :
                      wide16_s   ? {1'b0, data_s} :
                                   {5'h00, data_lo12};
    assign bin_full = !card_wide ? &data_lo8 :
                      wide16_s   ? &data_s : &data_lo12;

    // ------------------------------------------------------------
    // weighted digit sum
    // ------------------------------------------------------------
    function automatic logic [MAG_W-1:0] pdrd_wsum(
        input logic [3:0] d4,
        input logic [3:0] d3,
        input logic [3:0] d2,
        input logic [3:0] d1,
        input logic [3:0] d0
    );
        pdrd_wsum = {13'h0000, d4} * W_TEN_THOUSAND
                  + {13'h0000, d3} * W_THOUSAND
                  + {13'h0000, d2} * W_HUNDRED
                  + {13'h0000, d1} * W_TEN
                  + {13'h0000, d0};
    endfunction

    // ------------------------------------------------------------
    // signed bcd decode
    // ------------------------------------------------------------
    logic [3:0] digit_w [4];
    logic [3:0] used_d  [4];
    logic [3:0] dig_bad;
    logic [3:0] used_w;
    logic [3:0] check_w;
    logic       bcd_bad;
    logic [MAG_W-1:0] bcd_mag;

    assign used_w  = !card_wide ? USED_NARROW : wide16_s ? USED_W16 : USED_W12;
    assign check_w = !card_wide ? CHECK_NARROW : used_w;

    genvar g;
    for (g = 0; g < 4; g++) begin : g_digit
        assign digit_w[g] = data_s[4*g+3 -: 4];
        assign used_d[g]  = digit_w[g] & {4{used_w[g]}};
        assign dig_bad[g] = check_w[g] && (digit_w[g] > BCD_DIGIT_MAX);
    end

    assign bcd_bad = |dig_bad;
    assign bcd_mag = pdrd_wsum(4'h0, used_d[3], used_d[2], used_d[1], used_d[0]);

    // ------------------------------------------------------------
    // unsigned five-digit bcd decode
    // ------------------------------------------------------------
    logic [3:0] b5_d1;
    logic [3:0] b5_d2;
    logic [3:0] b5_d3;
    logic [3:0] b5_d4;
    logic [3:0] b5_d5;
    logic       b5_bad;
    logic [MAG_W-1:0] b5_mag;

    assign b5_d1  = {data_s[2:0], 1'b0};
    assign b5_d2  = data_s[6:3];
    assign b5_d3  = data_s[10:7];
    assign b5_d4  = data_s[14:11];
    assign b5_d5  = {2'h0, sign_s, data_s[15]};
    assign b5_bad = (b5_d1 > BCD_DIGIT_MAX) || (b5_d2 > BCD_DIGIT_MAX)
                 || (b5_d3 > BCD_DIGIT_MAX) || (b5_d4 > BCD_DIGIT_MAX);
    assign b5_mag = pdrd_wsum(b5_d5, b5_d4, b5_d3, b5_d2, b5_d1);

    // ------------------------------------------------------------
    // selection of the next reference
    // ------------------------------------------------------------
    logic             dec_bad;
    logic             take_w;
    logic [MAG_W-1:0] mag_nxt;
    logic             rev_nxt;
    logic [REF_W-1:0] ref_nxt;

    assign dec_bad = fault_w || (is_bcd && bcd_bad) || (is_bcd5 && b5_bad);
    assign take_w  = strobe_s && !dec_bad;
    assign mag_nxt = is_binary ? bin_mag : is_bcd5 ? b5_mag : bcd_mag;
    assign rev_nxt = is_bcd5 ? 1'b0 : sign_s;
    assign ref_nxt = rev_nxt ? (REF_RESET - {1'b0, mag_nxt}) : {1'b0, mag_nxt};

    // ------------------------------------------------------------
    // unit decode
    // ------------------------------------------------------------
    logic       hz_nxt;
    logic [1:0] dec_nxt;
    logic [1:0] mon_nxt;

    always_comb begin
        hz_nxt  = 1'b0;
        dec_nxt = 2'h0;
        case (input_format_select)
            FMT_BCD_PCT1:   dec_nxt = 2'h0;
            FMT_BCD_PCT01:  dec_nxt = 2'h1;
            FMT_BCD_PCT001: dec_nxt = 2'h2;
            FMT_BCD_HZ1:    hz_nxt  = 1'b1;
            FMT_BCD_HZ01: begin
                hz_nxt  = 1'b1;
                dec_nxt = 2'h1;
            end
            FMT_BCD_HZ001, FMT_BCD_5DIG: begin
                hz_nxt  = 1'b1;
                dec_nxt = 2'h2;
            end
            default: dec_nxt = 2'h0;
        endcase
    end

    assign mon_nxt = (display_unit_select == REF_RESET[15:0]) ? MON_HZ001 :
                     (display_unit_select == DISP_PCT)        ? MON_PCT001 :
                     (display_unit_select < DISP_USER_MIN)    ? MON_RPM : MON_USER;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    pdrd_state_e state_r;
    pdrd_state_e state_nxt;

    always_comb begin
        case (state_r)
            st_idle, st_read, st_fault: begin
                if (fault_w) begin
                    state_nxt = st_fault;
                end else if (strobe_s) begin
                    state_nxt = st_read;
                end else begin
                    state_nxt = st_idle;
                end
            end
            default: state_nxt = st_idle;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= st_idle;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign format_fault = state_r == st_fault;
    assign read_active  = state_r == st_read;

    // ------------------------------------------------------------
    // reference capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reference_monitor    <= REF_RESET;
            reference_magnitude  <= MAG_RESET;
            reference_reverse    <= 1'b0;
            reference_full_scale <= 1'b0;
            reference_valid      <= 1'b0;
        end else if (take_w) begin
            reference_monitor    <= ref_nxt;
            reference_magnitude  <= mag_nxt;
            reference_reverse    <= rev_nxt;
            reference_full_scale <= is_binary && bin_full;
            reference_valid      <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            digit_error   <= 1'b0;
            unit_is_hz    <= 1'b0;
            unit_decimals <= 2'h0;
            unit_binary   <= 1'b0;
            monitor_unit  <= MON_HZ001;
        end else begin
            digit_error   <= strobe_s && ((is_bcd && bcd_bad) || (is_bcd5 && b5_bad));
            unit_is_hz    <= hz_nxt;
            unit_decimals <= dec_nxt;
            unit_binary   <= is_binary;
            monitor_unit  <= mon_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_take_bin12;
        take_w && is_binary && card_wide && !wide16_s;
    endsequence

    sequence s_take_bin16;
        take_w && is_binary && card_wide && wide16_s;
    endsequence

    sequence s_take_bcd5;
        take_w && is_bcd5;
    endsequence

    a_bin12_low_lines: assert property (s_take_bin12 |=> reference_magnitude == {5'h00, $past(data_lo12)})
        else $error("12-bit binary word wrong");
    a_bin16_all_lines: assert property (s_take_bin16 |=> reference_magnitude == {1'b0, $past(data_s)})
        else $error("16-bit binary word wrong");
    a_bcd12_value: assert property (take_w && is_bcd && card_wide && !wide16_s && data_lo12 == 12'h789
        |=> reference_magnitude == 17'h00315)
        else $error("3-digit bcd value wrong");
    a_bcd16_value: assert property (take_w && is_bcd && card_wide && wide16_s && data_s == 16'h1234
        |=> reference_magnitude == 17'h004d2)
        else $error("4-digit bcd value wrong");
    a_bcd_digit_reject: assert property (strobe_s && is_bcd && dig_bad[0]
        |=> digit_error && $stable(reference_monitor))
        else $error("bad bcd digit accepted");
    a_bcd5_even_fwd: assert property (s_take_bcd5 |=> !reference_reverse && !reference_magnitude[0])
        else $error("five-digit bcd sign or step wrong");
    a_bcd5_sign_top: assert property ((s_take_bcd5 and (sign_s && data_s == 16'h0000))
        |=> reference_magnitude == 17'h04e20)
        else $error("sign line not top digit weight two");
    a_bcd5_range: assert property (s_take_bcd5 |=> reference_magnitude <= BCD5_MAX)
        else $error("five-digit bcd out of range");
    a_narrow_no_bcd5: assert property (!card_wide && is_bcd5 ##1 !card_wide && is_bcd5
        |=> format_fault && $stable(reference_monitor))
        else $error("narrow card ran five-digit format");
    a_sign_direction: assert property (take_w && !is_bcd5 |=> reference_reverse == $past(sign_s))
        else $error("direction not from sign line");
    a_strobe_hold: assert property (!strobe_s |=> $stable(reference_monitor) && $stable(reference_reverse))
        else $error("reference changed without strobe");
    a_full_scale_flag: assert property ((s_take_bin16 and (data_s == 16'hffff))
        |=> reference_full_scale && reference_magnitude == 17'h0ffff)
        else $error("all-ones word not full scale");
    a_narrow_binary: assert property (take_w && is_binary && !card_wide
        |=> reference_magnitude == {9'h000, $past(data_lo8)})
        else $error("narrow binary word wrong");
    a_narrow_bcd_hi: assert property (take_w && is_bcd && !card_wide && data_lo8 == 8'hf9
        |=> reference_magnitude == 17'h0009f)
        else $error("narrow bcd high digit wrong");
    a_monitor_rpm: assert property (display_unit_select >= DISP_RPM_MIN && display_unit_select < DISP_USER_MIN
        |=> monitor_unit == MON_RPM && !unit_binary)
        else $error("monitor unit not rpm");
    a_unit_tenth_hz: assert property (input_format_select == FMT_BCD_HZ01 |=> unit_is_hz && unit_decimals == 2'h1)
        else $error("unit code wrong");
    a_capture_whole: assert property (take_w |=> reference_monitor == $past(ref_nxt) && reference_valid)
        else $error("capture not on one edge");

endmodule

// ==== rtl/pdrd_pin_sync.sv ====
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module pdrd_pin_sync
    import pdrd_pkg::*;
#(
    parameter int W = SYNC_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // ------------------------------------------------------------
    // per-bit stages
    // ------------------------------------------------------------
    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                s1_r[g]    <= 1'b0;
                s2_r[g]    <= 1'b0;
                s3_r[g]    <= 1'b0;
                pin_out[g] <= 1'b0;
            end else begin
                s1_r[g] <= pin_in[g];
                s2_r[g] <= s1_r[g];
                s3_r[g] <= s2_r[g];
                if (s2_r[g] == s3_r[g]) begin
                    pin_out[g] <= s3_r[g];
                end
            end
        end
    end

endmodule

// ==== rtl/pdrd_pkg.sv ====
// constants and types of the parallel digital reference decoder
// ----------------------------------------------------------------
// Overview of operation
// - binary, 12-bit switch: lines one to twelve weigh 2^0..2^11, rest ignored
// - binary, 16-bit switch: sixteen lines weigh 2^0..2^15, lowest first
// - bcd codes 0-5, 12-bit: three digits 0-9, weights 1,2,4,8
// - bcd codes 0-5, 16-bit: four signed digits, each limited to 0-9
// - five-digit bcd: lines shifted one weight, low digit even 0-8, top 0-3
// - five-digit bcd: sign line is top digit weight two, forward only
// - five-digit bcd spans 0.00 to 399.98 Hz, least step 0.02 Hz
// - five-digit bcd works only on the wide card with the 16-bit switch, otherwise stops
// - data lines are read only while the read strobe is 1
// - binary word of all ones is the full-scale reference
// - narrow card binary: eight lines weigh 2^0..2^7
// - narrow card bcd: two signed digits, low 0-9, high 0-15
// - range and monitor unit follow display-unit and format settings
// - bcd codes 0-5 mean 1%,0.1%,0.01%,1Hz,0.1Hz,0.01Hz; 7 is binary for display units 0-1
// ----------------------------------------------------------------
package pdrd_pkg;

    // ------------------------------------------------------------
    // format codes
    // ------------------------------------------------------------
    localparam logic [2:0] FMT_BCD_PCT1   = 3'h0;
    localparam logic [2:0] FMT_BCD_PCT01  = 3'h1;
    localparam logic [2:0] FMT_BCD_PCT001 = 3'h2;
    localparam logic [2:0] FMT_BCD_HZ1    = 3'h3;
    localparam logic [2:0] FMT_BCD_HZ01   = 3'h4;
    localparam logic [2:0] FMT_BCD_HZ001  = 3'h5;
    localparam logic [2:0] FMT_BCD_5DIG   = 3'h6;
    localparam logic [2:0] FMT_BINARY     = 3'h7;

    // ------------------------------------------------------------
    // widths and pin positions
    // ------------------------------------------------------------
    localparam int DATA_W          = 16;
    localparam int MAG_W           = 17;
    localparam int REF_W           = 18;
    localparam int SYNC_W          = 19;
    localparam int SYNC_SIGN_BIT   = 16;
    localparam int SYNC_STROBE_BIT = 17;
    localparam int SYNC_WIDTH_BIT  = 18;

    // ------------------------------------------------------------
    // digit limits, weights and masks
    // ------------------------------------------------------------
    localparam logic [3:0]  BCD_DIGIT_MAX  = 4'h9;
    localparam logic [16:0] W_TEN          = 17'h0000a;
    localparam logic [16:0] W_HUNDRED      = 17'h00064;
    localparam logic [16:0] W_THOUSAND     = 17'h003e8;
    localparam logic [16:0] W_TEN_THOUSAND = 17'h02710;
    localparam logic [16:0] BCD5_MAX       = 17'h09c3e;
    localparam logic [3:0]  USED_NARROW    = 4'h3;
    localparam logic [3:0]  CHECK_NARROW   = 4'h1;
    localparam logic [3:0]  USED_W12       = 4'h7;
    localparam logic [3:0]  USED_W16       = 4'hf;

    // ------------------------------------------------------------
    // display unit thresholds and monitor units
    // ------------------------------------------------------------
    localparam logic [15:0] DISP_PCT      = 16'h0001;
    localparam logic [15:0] DISP_RPM_MIN  = 16'h0002;
    localparam logic [15:0] DISP_USER_MIN = 16'h0028;
    localparam logic [1:0]  MON_HZ001     = 2'h0;
    localparam logic [1:0]  MON_PCT001    = 2'h1;
    localparam logic [1:0]  MON_RPM       = 2'h2;
    localparam logic [1:0]  MON_USER      = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [REF_W-1:0]  REF_RESET = 18'h00000;
    localparam logic [MAG_W-1:0]  MAG_RESET = 17'h00000;
    localparam logic [SYNC_W-1:0] PIN_RESET = 19'h00000;

    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_read  = 3'b010,
        st_fault = 3'b100
    } pdrd_state_e;

endpackage

// ==== sim/pdrd_ctrl_model.sv ====
// controller model driving the parallel reference lines
`timescale 1ns/10ps
module pdrd_ctrl_model
    import pdrd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [DATA_W-1:0] word,
    input  wire logic              sign,
    input  wire logic              go,
    output logic      [DATA_W-1:0] data_lines,
    output logic                   sign_line,
    output logic                   read_strobe
);
    // ------------------------------------------------------------
    // line drive: word held while strobed, lines churn otherwise
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_lines  <= '0;
            sign_line   <= 1'b0;
            read_strobe <= 1'b0;
        end else begin
            read_strobe <= go;
            if (go) begin
                data_lines <= word;
                sign_line  <= sign;
            end else begin
                data_lines <= ~data_lines;
                sign_line  <= ~sign_line;
            end
        end
    end
endmodule

// ==== sim/pdrd_decoder_tb.sv ====
// self-checking bench of the parallel reference decoder
`timescale 1ns/10ps
module pdrd_decoder_tb;
    import pdrd_pkg::*;
    logic clk, rst, go, sgn, wsw, card, es, ef, ea;
    logic [DATA_W-1:0] word, dl;
    logic sl, rs, rev, fs, val, hz, bin, de, ff, ra;
    logic [2:0] fmt;
    logic [15:0] disp;
    logic [REF_W-1:0] mon;
    logic [MAG_W-1:0] mag;
    logic [1:0] dec, mu;
    int err_total, compares, cyc;
    pdrd_ctrl_model ctrl (.clk(clk), .rst(rst), .word(word), .sign(sgn), .go(go),
        .data_lines(dl), .sign_line(sl), .read_strobe(rs));
    pdrd_decoder uut (.clk(clk), .rst(rst), .data_lines(dl), .sign_line(sl), .read_strobe(rs),
        .width_switch(wsw), .card_wide(card), .input_format_select(fmt), .display_unit_select(disp),
        .reference_monitor(mon), .reference_magnitude(mag), .reference_reverse(rev),
        .reference_full_scale(fs), .reference_valid(val), .unit_is_hz(hz), .unit_decimals(dec),
        .unit_binary(bin), .monitor_unit(mu), .digit_error(de), .format_fault(ff), .read_active(ra));
    // ------------------------------------------------------------
    // clock, reset and timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cfg(input logic [2:0] f, input logic w, input logic c, input logic [15:0] d);
        @(posedge clk);
        fmt <= f;
        wsw <= w;
        card <= c;
        disp <= d;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic apply(input logic [15:0] w, input logic s);
        @(posedge clk);
        go <= 1'b1;
        word <= w;
        sgn <= s;
        repeat (8) @(posedge clk);
        #1;
        es = de;
        ef = ff;
        ea = ra;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        err_total = 0; compares = 0; cyc = 0;
        go = 1'b0; word = '0; sgn = 1'b0; wsw = 1'b1; card = 1'b1; fmt = 3'h7; disp = 16'h0000;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        cfg(3'h7, 1'b1, 1'b1, 16'h0000);
        check("valid", {31'h0, val}, 32'h0);
        apply(16'h1234, 1'b0);
        check("mon", mon, 32'h01234);
        check("active", {31'h0, ea}, 32'h1);
        check("valid", {31'h0, val}, 32'h1);
        apply(16'hffff, 1'b1);
        check("mag", mag, 32'h0ffff);
        check("full", {31'h0, fs}, 32'h1);
        check("rev", {31'h0, rev}, 32'h1);
        cfg(3'h7, 1'b0, 1'b1, 16'h0000);
        apply(16'hf123, 1'b0);
        check("mon", mon, 32'h00123);
        check("full", {31'h0, fs}, 32'h0);
        $display("test binary done");
        cfg(3'h3, 1'b0, 1'b1, 16'h0000);
        apply(16'h0789, 1'b1);
        check("mon", mon, 32'h3fceb);
        cfg(3'h0, 1'b1, 1'b1, 16'h0000);
        apply(16'h1234, 1'b0);
        check("mon", mon, 32'h004d2);
        apply(16'h12a4, 1'b0);
        check("digerr", {31'h0, es}, 32'h1);
        check("mon", mon, 32'h004d2);
        $display("test bcd done");
        cfg(3'h6, 1'b1, 1'b1, 16'h0000);
        apply(16'hcccc, 1'b1);
        check("mon", mon, 32'h09c3e);
        check("rev", {31'h0, rev}, 32'h0);
        apply(16'h0000, 1'b1);
        check("mon", mon, 32'h04e20);
        apply(16'h0001, 1'b0);
        check("mon", mon, 32'h00002);
        cfg(3'h6, 1'b0, 1'b1, 16'h0000);
        apply(16'h0008, 1'b0);
        check("fault", {31'h0, ef}, 32'h1);
        cfg(3'h6, 1'b1, 1'b0, 16'h0000);
        apply(16'h0008, 1'b0);
        check("fault", {31'h0, ef}, 32'h1);
        check("mon", mon, 32'h00002);
        $display("test five digit done");
        cfg(3'h7, 1'b1, 1'b0, 16'h0000);
        apply(16'hff12, 1'b0);
        check("mon", mon, 32'h00012);
        cfg(3'h0, 1'b1, 1'b0, 16'h0000);
        apply(16'h00f9, 1'b0);
        check("mon", mon, 32'h0009f);
        apply(16'h009a, 1'b0);
        check("digerr", {31'h0, es}, 32'h1);
        $display("test narrow done");
        for (int c = 0; c < 6; c++) begin
            cfg(c[2:0], 1'b1, 1'b1, 16'h0000);
            check("hz", {31'h0, hz}, {31'h0, c >= 3});
            check("dec", {30'h0, dec}, c % 3);
        end
        cfg(3'h7, 1'b1, 1'b1, 16'h0000);
        check("bin", {31'h0, bin}, 32'h1);
        cfg(3'h0, 1'b1, 1'b1, 16'h0001);
        check("unit", {30'h0, mu}, 32'h1);
        cfg(3'h0, 1'b1, 1'b1, 16'h0005);
        check("unit", {30'h0, mu}, 32'h2);
        cfg(3'h7, 1'b1, 1'b1, 16'h0005);
        check("bin", {31'h0, bin}, 32'h0);
        apply(16'h0042, 1'b0);
        check("mon", mon, 32'h0002a);
        cfg(3'h0, 1'b1, 1'b1, 16'h0028);
        check("unit", {30'h0, mu}, 32'h3);
        $display("test units done");
        tally_and_finish();
    end
endmodule
